/* bench/motion_cmd_properties.sv */
// link checks between host end and decoder end
// assumes one clock and the active-low asynchronous reset
module motion_cmd_properties
    import motion_cmd_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        wr_stb,
    input wire logic [1:0]  wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic        busy,
    input wire logic [15:0] read_data_low,
    input wire logic [15:0] read_data_high
);
    logic       low_stb, high_stb, cmd_stb, wide, short;
    logic [5:0] busy_cnt_r;
    // decoded strobes; wide and short by data length
    assign low_stb  = wr_stb && (wr_addr == LINK_DATA_LOW);
    assign high_stb = wr_stb && (wr_addr == LINK_DATA_HIGH);
    assign cmd_stb  = wr_stb && (wr_addr == LINK_CMD);
    assign wide     = wr_data[7:0] inside {C_RANGE, [C_PULSE:C_CMPLO]};
    assign short    = wr_data[7:0] inside {[C_JERK:C_SPEED], C_AOFS};
    // length of the running busy window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) busy_cnt_r <= 6'h00;
        else busy_cnt_r <= busy ? busy_cnt_r + 6'h01 : 6'h00;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_pair; low_stb ##1 high_stb; endsequence
    sequence s_window; busy [*8]; endsequence
    a_busy_rise: assert property (cmd_stb && !busy |=> s_window)
        else $error("busy did not follow a command");
    a_busy_length: assert property ($fell(busy) |-> busy_cnt_r == 6'(CMD_CYC))
        else $error("busy window length wrong");
    a_cmd_idle: assert property (cmd_stb |-> !busy)
        else $error("command sent while busy");
    a_code_defined: assert property (cmd_stb |-> wr_data[15:10] == 6'h00 &&
        wr_data[9:8] != 2'h0 && wr_data[7:0] inside {[8'h00:8'h0d], 8'h0f, [8'h10:8'h14],
        [8'h20:8'h27], 8'h30, [8'h32:8'h34], [8'h36:8'h3e]})
        else $error("undefined command on link");
    a_read_hold: assert property (!$stable({read_data_high, read_data_low})
        |-> $past(cmd_stb && !busy)) else $error("read words changed with no command");
    a_pair_cmd: assert property (s_pair |=> cmd_stb && wide)
        else $error("two data words not followed by a wide command");
    a_short_load: assert property (cmd_stb && short |-> $past(low_stb))
        else $error("two-byte code without its low word");
    a_wide_load: assert property (cmd_stb && wide |->
        $past(high_stb) && $past(low_stb, 2)) else $error("four-byte code without both words");
endmodule

/* bench/tb_motion_command_decoder.sv */
// bench: host end and decoder end joined by the link, driven over AHB
// assumes one 100 MHz clock; the master lives in the tasks below
module tb_motion_command_decoder import motion_cmd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic                         hclk, hresetn, hwrite, hreadyout, fixed, minus, bpen, decv;
    logic [1:0]                   htrans, fault, go, hold;
    logic [31:0]                  haddr, hwdata, hrdata, mx_in;
    logic [1:0][31:0]             lp_in, ep_in;
    logic [1:0][15:0]             cv_in, ca_in;
    logic [1:0][NPARAM-1:0][31:0] prm;
    logic [7:0]                   kind;
    int                           fails, checks, gos;
    cmd_link link_if ();
    motion_cmd_host motion_cmd_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .link(link_if));
    motion_cmd_device motion_cmd_device_inst (.hclk(hclk), .hresetn(hresetn), .link(link_if),
        .logic_pos_in(lp_in), .enc_pos_in(ep_in), .cur_speed_in(cv_in), .cur_accel_in(ca_in),
        .max_finish_in(mx_in), .param_out(prm), .param_fault(fault), .lp_preset(),
        .ep_preset(), .drive_go(go), .drive_fixed(fixed), .drive_minus(minus),
        .drive_hold(hold), .stop_clear(), .decel_stop(), .sudden_stop(), .interp_go(),
        .interp_kind(kind), .bp_write_en(bpen), .bp_push(), .bp_clear(), .interp_step(),
        .decel_valid(decv), .interp_int_clear(), .max_finish_clear());
    motion_cmd_properties motion_cmd_properties_inst (.hclk(hclk), .hresetn(hresetn),
        .wr_stb(link_if.wr_stb), .wr_addr(link_if.wr_addr), .wr_data(link_if.wr_data),
        .busy(link_if.busy), .read_data_low(link_if.read_data_low),
        .read_data_high(link_if.read_data_high));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // drive pulses are one cycle wide, so they are tallied as they pass
    always @(posedge hclk) if (go[0] === 1'b1) gos++;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one whole-word transfer; waits on hready in both phases
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // data word, command word, then poll until the sequencer is idle
    task cmd(input logic [1:0] ax, input logic [7:0] c, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, H_PARAM, d, r);
        ahb(1'b1, H_CMD, {22'h0, ax, c}, r);
        repeat (2) @(posedge hclk);
        do ahb(1'b0, H_STATUS, 32'h0, r); while (r[0] !== 1'b0);
    endtask
    task t_params;
        logic [31:0] v;
        for (int i = 0; i < 7; i++) begin
            v = (i == 0) ? RANGE_MIN : (i == 6) ? PULSE_MAX : SPD_MAX;
            cmd(2'h3, 8'(i), v);
            chk(prm[0][i], v);
            chk(prm[1][i], v);
        end
        chk({30'h0, fault}, 32'h0);
        $display("test params done");
    endtask
    task t_reads;
        logic [31:0] r, e[5];
        e = '{32'hfffffffe, 32'h80000000, 32'h00001f40, 32'h00000001, 32'h007fffff};
        cmd(2'h1, C_LPSET, e[0]);
        chk(prm[0][9], e[0]);
        for (int i = 0; i < 5; i++) begin
            cmd(2'h1, C_RD_LP + 8'(i), 32'h0);
            ahb(1'b0, H_READ, 32'h0, r);
            chk(r, e[i]);
        end
        $display("test reads done");
    endtask
    task t_drive;
        int g;
        cmd(2'h1, C_RANGE, RANGE_MIN - 32'd1);
        g = gos;
        cmd(2'h1, C_DRV_FP, 32'h0);
        chk(gos, g);
        cmd(2'h1, C_RANGE, RANGE_MAX);
        cmd(2'h1, C_DRV_CM, 32'h0);
        chk(gos, g + 1);
        chk({30'h0, fixed, minus}, 32'h1);
        $display("test drive done");
    endtask
    task t_modes;
        logic [7:0]  c[8];
        logic [10:0] e[8];
        c = '{C_HOLD, C_BPEN, C_DECV, C_CW, C_REL, C_BPDIS, C_DECI, C_BPI};
        e = '{11'h400, 11'h600, 11'h700, 11'h732, 11'h332, 11'h132, 11'h032, 11'h034};
        for (int i = 0; i < 8; i++) begin
            cmd(2'h3, c[i], 32'h0);
            chk(32'({hold[0], bpen, decv, kind}), 32'(e[i]));
        end
        $display("test modes done");
    endtask
    task give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata, fails, checks, gos} = '0;
        lp_in = {32'h0, 32'hfffffffe};
        ep_in = {32'h0, 32'h80000000};
        cv_in = {16'h0, 16'h1f40};
        ca_in = {16'h0, 16'h0001};
        mx_in = 32'h007fffff;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_params;
        t_reads;
        t_drive;
        t_modes;
        give_verdict;
    end
    // about 40 cycles per command; ample room
    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        give_verdict;
    end
endmodule

/* hdl/cmd_link.sv */
// parallel register link between host controller and command decoder;
// both ends run on the same clock, so nothing here is synchronised
interface cmd_link;
    logic        wr_stb;           // one-cycle write strobe
    logic [1:0]  wr_addr;          // data low, data high or command
    logic [15:0] wr_data;
    logic        busy;             // command being taken
    logic [15:0] read_data_low;
    logic [15:0] read_data_high;
    modport device (input wr_stb, wr_addr, wr_data,
                    output busy, read_data_low, read_data_high);
    modport host (output wr_stb, wr_addr, wr_data,
                  input busy, read_data_low, read_data_high);
endinterface

/* hdl/motion_cmd_device.sv */
// command decoder end: data and command writes over the link, per-axis
// parameter store, drive/interpolation pulses and read registers
// assumes the host honours busy and the data lengths of each code
// Functional notes
// - read value split low and high words
// - read values binary, negatives two's complement
// - read codes 10h..14h select sources
// - host loads low, high if four bytes
// - multi-axis write stores into each axis
// - code 00h loads range 16,000..8,000,000
// - codes 01..05 load 16-bit speeds
// - code 06 loads pulse count or point
// - codes 07, 08 load decel and center
// - codes 09, 0A preset position counters
// - codes 0B, 0C load compare values
// - 0D loads offset, 0F switches read axis
// - codes 20h..23 start fixed or continuous
// - 24 hold, 25 release, 26/27 stop
// - codes 30h..34 start interpolation kinds
// - 36..39 bit pattern enable, push, clear
// - 3A step, 3B/3C decel, 3D, 3E clears
// - host writes every byte of parameter
// - out-of-range parameter blocks driving
// - host waits 250 ns between commands
// - only offset defined after reset
// - host never sends undefined codes
module motion_cmd_device
    import motion_cmd_pkg::*;
#(
    parameter int AXES = 2
) (
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    cmd_link.device                           link,
    input  wire logic [AXES-1:0][31:0]        logic_pos_in,
    input  wire logic [AXES-1:0][31:0]        enc_pos_in,
    input  wire logic [AXES-1:0][15:0]        cur_speed_in,
    input  wire logic [AXES-1:0][15:0]        cur_accel_in,
    input  wire logic [31:0]                  max_finish_in,
    output logic [AXES-1:0][NPARAM-1:0][31:0] param_out,
    output logic [AXES-1:0]                   param_fault,
    output logic [AXES-1:0]                   lp_preset,
    output logic [AXES-1:0]                   ep_preset,
    output logic [AXES-1:0]                   drive_go,
    output logic                              drive_fixed,
    output logic                              drive_minus,
    output logic [AXES-1:0]                   drive_hold,
    output logic [AXES-1:0]                   stop_clear,
    output logic [AXES-1:0]                   decel_stop,
    output logic [AXES-1:0]                   sudden_stop,
    output logic                              interp_go,
    output logic [7:0]                        interp_kind,
    output logic                              bp_write_en,
    output logic                              bp_push,
    output logic                              bp_clear,
    output logic                              interp_step,
    output logic                              decel_valid,
    output logic                              interp_int_clear,
    output logic                              max_finish_clear
);
    localparam logic [7:0] BUSY_LOAD = 8'(CMD_CYC);

    if (AXES < 1 || AXES > 2) begin : g_chk
        $error("AXES must be 1 or 2");
    end

    logic [15:0]     dlow_r;
    logic [15:0]     dhigh_r;
    logic [7:0]      busy_cnt_r;
    logic            busy_r;
    logic            rd_axis_r;
    logic            cmd_go;
    logic [7:0]      code;
    logic [AXES-1:0] axes;
    logic [31:0]     val32;
    logic [15:0]     rd_lo;
    logic [15:0]     rd_hi;
    logic            sel_axis;
    logic [AXES-1:0][NPARAM-1:0] bad_r;
    logic            all_ok;

    // is the staged data inside the permitted range for a write code
    function automatic logic in_range(input logic [7:0] c, input logic [31:0] v);
        logic s24;
        logic s30;
        s24 = (v[31:23] == 9'h000) || (v[31:23] == 9'h1ff);
        s30 = ($signed(v) <= 32'sd1073741824) && ($signed(v) >= -32'sd1073741824);
        case (c)
            C_RANGE:  in_range = (v >= RANGE_MIN) && (v <= RANGE_MAX);
            C_JERK:   in_range = (v[15:0] != 16'h0000);
            8'h02, 8'h03, 8'h04, C_SPEED:
                      in_range = (v[15:0] != 16'h0000) && ({16'h0000, v[15:0]} <= SPD_MAX);
            C_PULSE:  in_range = (v <= PULSE_MAX) || s24; // count or finish point
            C_DECPT:  in_range = (v <= PULSE_MAX);
            C_CENTER: in_range = s24;
            C_CMPHI, C_CMPLO: in_range = s30;
            default:  in_range = 1'b1;
        endcase
    endfunction

    assign cmd_go   = link.wr_stb && (link.wr_addr == LINK_CMD) && !busy_r;
    assign code     = link.wr_data[CODE_LSB +: 8];
    assign axes     = link.wr_data[AXIS_LSB +: AXES];
    assign val32    = {dhigh_r, dlow_r};
    assign sel_axis = (AXES > 1) && !axes[0] ? 1'b1 : 1'b0;
    assign all_ok   = ~|bad_r;

    // staging words; a two-byte code only ever looks at the low word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dlow_r  <= 16'h0000;
            dhigh_r <= 16'h0000;
        end else if (link.wr_stb && !busy_r) begin
            if (link.wr_addr == LINK_DATA_LOW) begin
                dlow_r <= link.wr_data;
            end
            if (link.wr_addr == LINK_DATA_HIGH) begin
                dhigh_r <= link.wr_data;
            end
        end
    end

    // command access window; writes inside it are ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_cnt_r <= 8'h00;
            busy_r     <= 1'b0;
        end else if (cmd_go) begin
            busy_cnt_r <= BUSY_LOAD - 8'h01;
            busy_r     <= 1'b1;
        end else if (busy_cnt_r != 8'h00) begin
            busy_cnt_r <= busy_cnt_r - 8'h01;
        end else begin
            busy_r <= 1'b0;
        end
    end
    assign link.busy = busy_r;

    // per-axis parameter store and range bookkeeping
    for (genvar a = 0; a < AXES; a++) begin : g_axis
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                param_out[a] <= '0; // offset defined zero, rest held zero
                bad_r[a]     <= '0;
            end else if (cmd_go && axes[a] && code < 8'(NPARAM) && code != 8'h0e) begin
                // same value lands in every selected axis
                if ((code >= C_JERK && code <= C_SPEED) || code == C_AOFS) begin
                    param_out[a][code[3:0]] <= {16'h0000, dlow_r};
                end else begin
                    param_out[a][code[3:0]] <= val32;
                end
                bad_r[a][code[3:0]] <= !in_range(code, val32);
            end
        end

        // presets, drive, hold and stops
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                lp_preset[a]   <= 1'b0;
                ep_preset[a]   <= 1'b0;
                drive_go[a]    <= 1'b0;
                drive_hold[a]  <= 1'b0;
                stop_clear[a]  <= 1'b0;
                decel_stop[a]  <= 1'b0;
                sudden_stop[a] <= 1'b0;
                param_fault[a] <= 1'b0;
            end else begin
                param_fault[a] <= |bad_r[a];
                lp_preset[a]   <= cmd_go && axes[a] && code == C_LPSET;
                ep_preset[a]   <= cmd_go && axes[a] && code == C_EPSET;
                // a faulted axis never starts
                drive_go[a]    <= cmd_go && axes[a] && code >= C_DRV_FP && code <= C_DRV_CM
                                  && !(|bad_r[a]);
                stop_clear[a]  <= cmd_go && axes[a] && code == C_REL;
                decel_stop[a]  <= cmd_go && axes[a] && code == C_DSTOP;
                sudden_stop[a] <= cmd_go && axes[a] && code == C_SSTOP;
                if (cmd_go && axes[a] && code == C_HOLD) begin
                    drive_hold[a] <= 1'b1;
                end else if (cmd_go && axes[a] && code == C_REL) begin
                    drive_hold[a] <= 1'b0;
                end
            end
        end
    end

    // direction and mode travel with the start pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_fixed <= 1'b0;
            drive_minus <= 1'b0;
        end else if (cmd_go && code >= C_DRV_FP && code <= C_DRV_CM) begin
            drive_fixed <= !code[1];
            drive_minus <= code[0];
        end
    end

    // interpolation and bit pattern controls; only the interpolation start needs every axis clean
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interp_go        <= 1'b0;
            interp_kind      <= 8'h00;
            bp_write_en      <= 1'b0;
            bp_push          <= 1'b0;
            bp_clear         <= 1'b0;
            interp_step      <= 1'b0;
            decel_valid      <= 1'b0;
            interp_int_clear <= 1'b0;
            max_finish_clear <= 1'b0;
        end else begin
            interp_go <= cmd_go && all_ok
                         && (code == C_LIN || code == C_CW || code == C_CCW || code == C_BPI);
            if (cmd_go && (code == C_LIN || code == C_CW || code == C_CCW || code == C_BPI)) begin
                interp_kind <= code;
            end
            bp_push          <= cmd_go && code == C_BPPUSH;
            bp_clear         <= cmd_go && code == C_BPCLR;
            interp_step      <= cmd_go && code == C_STEP;
            interp_int_clear <= cmd_go && code == C_INTCLR;
            max_finish_clear <= cmd_go && code == C_MXCLR;
            if (cmd_go && code == C_BPEN) begin
                bp_write_en <= 1'b1;
            end else if (cmd_go && code == C_BPDIS) begin
                bp_write_en <= 1'b0;
            end
            if (cmd_go && code == C_DECV) begin
                decel_valid <= 1'b1;
            end else if (cmd_go && code == C_DECI) begin
                decel_valid <= 1'b0;
            end
        end
    end

    // read source; 16-bit values zero-extend, counts keep their sign bits
    always_comb begin
        rd_lo = 16'h0000;
        rd_hi = 16'h0000;
        case (code)
            C_RD_LP: {rd_hi, rd_lo} = logic_pos_in[sel_axis];
            C_RD_EP: {rd_hi, rd_lo} = enc_pos_in[sel_axis];
            C_RD_CV: rd_lo = cur_speed_in[sel_axis];
            C_RD_CA: rd_lo = cur_accel_in[sel_axis];
            C_RD_MX: {rd_hi, rd_lo} = max_finish_in;
            default: rd_lo = 16'h0000;
        endcase
    end

    // read registers and the axis they refer to
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_axis_r           <= 1'b0;
            link.read_data_low  <= 16'h0000;
            link.read_data_high <= 16'h0000;
        end else if (cmd_go && code >= C_RD_LP && code <= C_RD_MX) begin
            rd_axis_r           <= sel_axis;
            link.read_data_low  <= rd_lo;
            link.read_data_high <= rd_hi;
        end else if (cmd_go && code == C_NOP) begin
            rd_axis_r <= sel_axis;
        end
    end
endmodule

/* hdl/motion_cmd_host.sv */
// host end: AHB-Lite slave with parameter, command, read and status words,
// and a sequencer that feeds the command decoder over the link
// assumes a single AHB master and the decoder on the same clock
module motion_cmd_host
    import motion_cmd_pkg::*;
#(
    parameter int AXES = 2
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    cmd_link.host            link
);
    typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_CMD, S_GAP, S_WAIT} seq_t;

    if (AXES < 1 || AXES > 2) begin : g_chk
        $error("AXES must be 1 or 2");
    end

    seq_t            st_r;
    logic            wpend_r;
    logic [7:0]      waddr_r;
    logic [31:0]     param_r;
    logic [7:0]      code_r;
    logic [AXES-1:0] axes_r;
    logic            reject_r;
    logic [AXES-1:0][6:0] preset_r;
    logic            cmd_wr;
    logic            legal;
    logic            ready_ok;
    logic [7:0]      wcode;
    logic [AXES-1:0] waxes;

    // codes that the decoder defines
    function automatic logic code_defined(input logic [7:0] c);
        code_defined = (c <= C_AOFS) || c == C_NOP || (c >= C_RD_LP && c <= C_RD_MX)
                       || (c >= C_DRV_FP && c <= C_SSTOP) || c == C_LIN
                       || (c >= C_CW && c <= C_BPI) || (c >= C_BPEN && c <= C_MXCLR);
    endfunction

    // parameters written as four bytes
    function automatic logic four_byte(input logic [7:0] c);
        four_byte = c == C_RANGE || (c >= C_PULSE && c <= C_CMPLO);
    endfunction

    assign wcode  = hwdata[CODE_LSB +: 8];
    assign waxes  = hwdata[AXIS_LSB +: AXES];
    assign cmd_wr = wpend_r && waddr_r == H_CMD;
    // drive needs range..pulse preset on each selected axis, interpolation on every axis
    always_comb begin
        ready_ok = 1'b1;
        for (int a = 0; a < AXES; a++) begin
            if ((waxes[a] || wcode[7:4] == 4'h3) && !(&preset_r[a])) begin
                ready_ok = 1'b0;
            end
        end
    end
    assign legal = code_defined(wcode) && waxes != '0 && st_r == S_IDLE
                   && (!(wcode[7:4] == 4'h2 && wcode[2:0] <= 3'h3) || ready_ok)
                   && !(wcode >= C_LIN && wcode <= C_BPI && !ready_ok);

    // AHB address phase capture and zero-wait responses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wpend_r   <= 1'b0;
            waddr_r   <= 8'h00;
            hrdata    <= RST_ZERO;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            wpend_r   <= hsel && htrans[1] && hready && hwrite;
            waddr_r   <= haddr[7:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                case (haddr[7:0])
                    H_PARAM:  hrdata <= param_r;
                    H_CMD:    hrdata <= {22'h0, 2'(axes_r), code_r};
                    H_READ:   hrdata <= {link.read_data_high, link.read_data_low};
                    H_STATUS: hrdata <= {30'h0, reject_r, st_r != S_IDLE};
                    default:  hrdata <= RST_ZERO;
                endcase
            end
        end
    end

    // parameter word, command capture and refusal flag; a new refusal wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            param_r  <= RST_ZERO;
            code_r   <= 8'h00;
            axes_r   <= '0;
            reject_r <= 1'b0;
            preset_r <= '0;
        end else begin
            if (wpend_r && waddr_r == H_PARAM) begin
                param_r <= hwdata;
            end
            if (cmd_wr && legal) begin
                code_r <= wcode;
                axes_r <= waxes;
                for (int a = 0; a < AXES; a++) begin
                    if (waxes[a] && wcode <= C_PULSE) begin
                        preset_r[a][wcode[2:0]] <= 1'b1;
                    end
                end
            end
            if (cmd_wr && !legal) begin
                reject_r <= 1'b1;
            end else if (wpend_r && waddr_r == H_STATUS && hwdata[1]) begin
                reject_r <= 1'b0;
            end
        end
    end

    // link sequencer: data words first, then the command, then the access gap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r         <= S_IDLE;
            link.wr_stb  <= 1'b0;
            link.wr_addr <= LINK_DATA_LOW;
            link.wr_data <= 16'h0000;
        end else begin
            link.wr_stb <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    if (cmd_wr && legal) begin
                        st_r <= wcode <= C_AOFS ? S_LOW : S_CMD;
                    end
                end
                S_LOW: begin
                    link.wr_stb  <= 1'b1;
                    link.wr_addr <= LINK_DATA_LOW;
                    link.wr_data <= param_r[15:0];
                    st_r         <= four_byte(code_r) ? S_HIGH : S_CMD;
                end
                S_HIGH: begin
                    link.wr_stb  <= 1'b1;
                    link.wr_addr <= LINK_DATA_HIGH;
                    link.wr_data <= param_r[31:16];
                    st_r         <= S_CMD;
                end
                S_CMD: begin
                    link.wr_stb  <= 1'b1;
                    link.wr_addr <= LINK_CMD;
                    link.wr_data <= {6'h00, 2'(axes_r), code_r};
                    st_r         <= S_GAP;
                end
                S_GAP: begin
                    st_r <= S_WAIT; // busy shows one cycle after the strobe
                end
                S_WAIT: begin
                    if (!link.busy) begin
                        st_r <= S_IDLE;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end
endmodule

/* hdl/motion_cmd_pkg.sv */
// constants shared by the command link ends: link addresses, command codes,
// host register offsets and timing; assumes a single 100 MHz clock
package motion_cmd_pkg;
    // link register selects
    localparam logic [1:0] LINK_DATA_LOW  = 2'h0;
    localparam logic [1:0] LINK_DATA_HIGH = 2'h1;
    localparam logic [1:0] LINK_CMD       = 2'h2;
    // command word layout
    localparam int CODE_LSB = 0;
    localparam int AXIS_LSB = 8;
    // parameter write codes
    localparam logic [7:0] C_RANGE  = 8'h00;
    localparam logic [7:0] C_JERK   = 8'h01;
    localparam logic [7:0] C_SPEED  = 8'h05;
    localparam logic [7:0] C_PULSE  = 8'h06;
    localparam logic [7:0] C_DECPT  = 8'h07;
    localparam logic [7:0] C_CENTER = 8'h08;
    localparam logic [7:0] C_LPSET  = 8'h09;
    localparam logic [7:0] C_EPSET  = 8'h0a;
    localparam logic [7:0] C_CMPHI  = 8'h0b;
    localparam logic [7:0] C_CMPLO  = 8'h0c;
    localparam logic [7:0] C_AOFS   = 8'h0d;
    localparam logic [7:0] C_NOP    = 8'h0f;
    localparam int         NPARAM   = 14;
    // read codes
    localparam logic [7:0] C_RD_LP  = 8'h10;
    localparam logic [7:0] C_RD_EP  = 8'h11;
    localparam logic [7:0] C_RD_CV  = 8'h12;
    localparam logic [7:0] C_RD_CA  = 8'h13;
    localparam logic [7:0] C_RD_MX  = 8'h14;
    // drive codes
    localparam logic [7:0] C_DRV_FP = 8'h20;
    localparam logic [7:0] C_DRV_CM = 8'h23;
    localparam logic [7:0] C_HOLD   = 8'h24;
    localparam logic [7:0] C_REL    = 8'h25;
    localparam logic [7:0] C_DSTOP  = 8'h26;
    localparam logic [7:0] C_SSTOP  = 8'h27;
    // interpolation codes
    localparam logic [7:0] C_LIN    = 8'h30;
    localparam logic [7:0] C_CW     = 8'h32;
    localparam logic [7:0] C_CCW    = 8'h33;
    localparam logic [7:0] C_BPI    = 8'h34;
    localparam logic [7:0] C_BPEN   = 8'h36;
    localparam logic [7:0] C_BPDIS  = 8'h37;
    localparam logic [7:0] C_BPPUSH = 8'h38;
    localparam logic [7:0] C_BPCLR  = 8'h39;
    localparam logic [7:0] C_STEP   = 8'h3a;
    localparam logic [7:0] C_DECV   = 8'h3b;
    localparam logic [7:0] C_DECI   = 8'h3c;
    localparam logic [7:0] C_INTCLR = 8'h3d;
    localparam logic [7:0] C_MXCLR  = 8'h3e;
    // parameter limits
    localparam logic [31:0] RANGE_MIN = 32'd16000;
    localparam logic [31:0] RANGE_MAX = 32'd8000000;
    localparam logic [31:0] SPD_MAX   = 32'd8000;
    localparam logic [31:0] PULSE_MAX = 32'd268435455;
    // command access time
    localparam int CMD_TIME_NS = 250;
    localparam int CLK_MHZ     = 100;
    localparam int CMD_CYC     = (CMD_TIME_NS * CLK_MHZ + 999) / 1000;
    // host register byte offsets
    localparam logic [7:0] H_PARAM  = 8'h00;
    localparam logic [7:0] H_CMD    = 8'h04;
    localparam logic [7:0] H_READ   = 8'h08;
    localparam logic [7:0] H_STATUS = 8'h0c;
    localparam logic [31:0] RST_ZERO = 32'h0;
endpackage
